// ===== shared/tcp_consts.svh
// register offsets, command opcodes, field positions and reset values
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH

`define TCP_OFF_DATA      8'h00
`define TCP_OFF_ADDR      8'h04
`define TCP_OFF_CMD       8'h08
`define TCP_OFF_STAT      8'h0C
`define TCP_OFF_FIFO      8'h10
`define TCP_OFF_CFG       8'h14

`define TCP_OP_CMWRITE    4'h7
`define TCP_OP_TRISTATE   4'h6
`define TCP_OP_CMREAD     4'h5
`define TCP_OP_CMRESET    4'h4

`define TCP_CFG_HS_BIT    0
`define TCP_CFG_PER_LSB   8
`define TCP_CFG_PER_MSB   15
`define TCP_STAT_BUSY_BIT 8
`define TCP_STAT_OVF_BIT  9

`define TCP_D_MSB         7
`define TCP_D_LSB         6
`define TCP_CI_MSB        5
`define TCP_CI_LSB        2
`define TCP_SIG_MSB       7
`define TCP_SIG_LSB       2
`define TCP_HS_MSB        1
`define TCP_HS_LSB        0

`define TCP_DIR_DN        1'b0
`define TCP_DIR_UP        1'b1
`define TCP_EVEN          1'b0
`define TCP_ODD           1'b1
`define TCP_HS_FORCED     2'h3
`define TCP_HS_RESET      1'b1
`define TCP_PERIOD_RESET  8'h01
`define TCP_TRI_RESET     4'h0
`define TCP_IDX_LAST      8'hFF
`define TCP_PAIR_MASK     8'h03

`endif

// ===== shared/tcp_pkg.sv
// types shared by the timeslot channel preprocessor
package tcp_pkg;
	// control memory codes
	typedef enum logic [3:0] {
		TCP_CODE_UNASSIGNED = 4'h0,
		TCP_CODE_SW64       = 4'h1,
		TCP_CODE_SW16_B10   = 4'h4,
		TCP_CODE_SW16_B32   = 4'h5,
		TCP_CODE_SW16_B54   = 4'h6,
		TCP_CODE_SW16_B76   = 4'h7,
		TCP_CODE_CI         = 4'h8,
		TCP_CODE_SIG        = 4'hA,
		TCP_CODE_HIZ        = 4'hB
	} tcp_code_e;
endpackage

// ===== logic/tcp_top.sv
// timeslot channel preprocessor: control memory, frame pipeline, apb
//
// Behaviour
// - even slot monitor; odd slot D, indication, handshake
// - handshake on: handler bits; off: forced ones
// - central scheme switches D bits at 16k
// - indication change queues slot address, flags processor
// - central scheme codes 1010/1000 and switched odd
// - 16k codes pick pcm bit pair
// - downstream 1011 floats D, upstream 0000 unassigned
// - code 0001 switches whole odd slot transparently
// - upstream pcm bit pairs floatable via tristate
// - downstream low pcm bits ANDed with handshake
// - signaling scheme: six bits plus handshake
// - forced handshake reachable with signaling via even
// - validated signaling change queues slot address
// - double last-look debounce, programmable period
// - signaling codes: actual even, stable odd
// - command 0111 loads code and data
// - decentral codes 1000, 1011, 1000, 0000
// - tristate command sets driven bit pairs
// - memory reset sets every code unassigned
// - decentral ignores upstream D, floats downstream D
`timescale 1ns/10ps
`include "tcp_consts.svh"

module tcp_top #(
	parameter int FIFO_AW = 4
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        fi_frame,
	input  wire logic        fi_strobe,
	input  wire logic [6:0]  fi_ts,
	input  wire logic [7:0]  fi_rx_byte,
	output logic      [7:0]  fi_tx_byte,
	output logic      [7:0]  fi_tx_oe,
	output logic             fi_tx_valid,
	input  wire logic [7:0]  mf_dn_byte,
	input  wire logic        mf_mr,
	input  wire logic        mf_mx,
	output logic      [7:0]  pcm_dn_ptr,
	input  wire logic [7:0]  pcm_dn_byte,
	output logic      [7:0]  pcm_up_ptr,
	output logic      [7:0]  pcm_up_byte,
	output logic      [7:0]  pcm_up_oe,
	output logic             pcm_up_valid,
	output logic             change_pending
);
	localparam int MEM_N  = 256;
	localparam int PAIR_N = 64;
	localparam int FIFO_N = 1 << FIFO_AW;

	// control memory: index {upstream, timeslot}; data memory: pcm slot
	logic [3:0]         control_memory_code [MEM_N];
	logic [7:0]         control_memory_data [MEM_N];
	logic [3:0]         data_memory_tri     [MEM_N];
	logic [5:0]         sig_last            [PAIR_N];
	logic [6:0]         fifo_mem            [FIFO_N];

	logic [7:0]         memory_access_data_reg;
	logic [7:0]         memory_access_address_reg;
	logic [3:0]         code_rd;
	logic               hs_en;
	logic [7:0]         period;
	logic [7:0]         frame_cnt;
	logic               sample_frame;
	logic               sweep_busy;
	logic [7:0]         sweep_idx;
	logic               s1_v;
	logic [6:0]         s1_ts;
	logic [7:0]         s1_rx;
	logic [FIFO_AW-1:0] wr_ptr;
	logic [FIFO_AW-1:0] rd_ptr;
	logic [FIFO_AW:0]   fifo_cnt;
	logic               ovf;

	logic               acc;
	logic               wr;
	logic               rd;
	logic               mapped;
	logic               wr_cmd;
	logic [3:0]         op;
	logic [7:0]         ev_dn;
	logic [7:0]         od_dn;
	logic [7:0]         ev_up;
	logic [7:0]         od_up;
	logic [1:0]         hs;
	logic [7:0]         next_tx_byte;
	logic [7:0]         next_tx_oe;
	logic [7:0]         next_up_byte;
	logic [7:0]         next_up_oe;
	logic               next_up_valid;
	logic               ci_upd;
	logic               sig_upd;
	logic               ci_change;
	logic               sig_change;
	logic               push;
	logic               pop;
	logic               full;

	// 16 kbit/s switching code test
	function automatic logic is_16k(input logic [3:0] c);
		return c == tcp_pkg::TCP_CODE_SW16_B76 ||
			c == tcp_pkg::TCP_CODE_SW16_B54 ||
			c == tcp_pkg::TCP_CODE_SW16_B32 ||
			c == tcp_pkg::TCP_CODE_SW16_B10;
	endfunction

	// mask of the pcm bit pair a 16k code selects
	function automatic logic [7:0] pair_mask(input logic [3:0] c);
		logic [7:0] m;
		m = `TCP_PAIR_MASK;
		unique case (c)
			tcp_pkg::TCP_CODE_SW16_B76: m = `TCP_PAIR_MASK << 6;
			tcp_pkg::TCP_CODE_SW16_B54: m = `TCP_PAIR_MASK << 4;
			tcp_pkg::TCP_CODE_SW16_B32: m = `TCP_PAIR_MASK << 2;
			default:                    m = `TCP_PAIR_MASK;
		endcase
		return m;
	endfunction

	// tristate field: one bit per pcm bit pair, set means driven
	function automatic logic [7:0] spread(input logic [3:0] t);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 4; i++) begin
			m[2*i]   = t[i];
			m[2*i+1] = t[i];
		end
		return m;
	endfunction

	// apb slave decode; no wait states, freezes with ce
	assign acc     = psel & penable & ce;
	assign wr      = acc & pwrite;
	assign rd      = acc & ~pwrite;
	assign op      = pwdata[7:4];
	assign wr_cmd  = wr && paddr == `TCP_OFF_CMD && !sweep_busy;
	assign mapped  = paddr == `TCP_OFF_DATA || paddr == `TCP_OFF_ADDR ||
		paddr == `TCP_OFF_CMD || paddr == `TCP_OFF_STAT ||
		paddr == `TCP_OFF_FIFO || paddr == `TCP_OFF_CFG;
	assign pready  = ce;
	assign pslverr = acc & ~mapped;

	// read mux; every source but change_pending is a flip-flop
	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			`TCP_OFF_DATA: prdata[7:0] = memory_access_data_reg;
			`TCP_OFF_ADDR: prdata[7:0] = memory_access_address_reg;
			`TCP_OFF_CMD:  prdata[3:0] = code_rd;
			`TCP_OFF_STAT: begin
				prdata[FIFO_AW:0]          = fifo_cnt;
				prdata[`TCP_STAT_BUSY_BIT] = sweep_busy;
				prdata[`TCP_STAT_OVF_BIT]  = ovf;
			end
			`TCP_OFF_FIFO: begin
				prdata[6:0] = fifo_mem[rd_ptr];
				prdata[7]   = change_pending;
			end
			`TCP_OFF_CFG: begin
				prdata[`TCP_CFG_HS_BIT] = hs_en;
				prdata[`TCP_CFG_PER_MSB:`TCP_CFG_PER_LSB] = period;
			end
			default: prdata = 32'h0000_0000;
		endcase
	end

	// address and config registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			memory_access_address_reg <= 8'h00;
			hs_en                     <= `TCP_HS_RESET;
			period                    <= `TCP_PERIOD_RESET;
		end else if (wr && paddr == `TCP_OFF_ADDR) begin
			memory_access_address_reg <= pwdata[7:0];
		end else if (wr && paddr == `TCP_OFF_CFG) begin
			hs_en  <= pwdata[`TCP_CFG_HS_BIT];
			period <= pwdata[`TCP_CFG_PER_MSB:`TCP_CFG_PER_LSB];
		end
	end

	// data register: software writes it, a memory read command loads it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			memory_access_data_reg <= 8'h00;
			code_rd                <= 4'h0;
		end else if (wr && paddr == `TCP_OFF_DATA) begin
			memory_access_data_reg <= pwdata[7:0];
		end else if (wr_cmd && op == `TCP_OP_CMREAD) begin
			memory_access_data_reg <=
				control_memory_data[memory_access_address_reg];
			code_rd <= control_memory_code[memory_access_address_reg];
		end
	end

	// memory reset sweep, one entry per cycle; also runs after rst_n
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sweep_busy <= 1'b1;
			sweep_idx  <= 8'h00;
		end else if (ce) begin
			if (sweep_busy) begin
				sweep_idx <= sweep_idx + 8'h01;
				if (sweep_idx == `TCP_IDX_LAST)
					sweep_busy <= 1'b0;
			end else if (wr_cmd && op == `TCP_OP_CMRESET) begin
				sweep_busy <= 1'b1;
				sweep_idx  <= 8'h00;
			end
		end
	end

	// debounce sampling period counted in frames
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frame_cnt    <= 8'h00;
			sample_frame <= 1'b1;
		end else if (ce && fi_frame) begin
			sample_frame <= frame_cnt == 8'h00;
			if (frame_cnt == 8'h00 || frame_cnt >= period)
				frame_cnt <= (period == 8'h00) ? 8'h00 : period - 8'h01;
			else
				frame_cnt <= frame_cnt - 8'h01;
		end
	end

	// stage 1: latch the slot and fetch the downstream pcm pointer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_v       <= 1'b0;
			s1_ts      <= 7'h00;
			s1_rx      <= 8'h00;
			pcm_dn_ptr <= 8'h00;
		end else if (ce) begin
			s1_v <= fi_strobe & ~sweep_busy;
			if (fi_strobe) begin
				s1_ts      <= fi_ts;
				s1_rx      <= fi_rx_byte;
				pcm_dn_ptr <= control_memory_data[{`TCP_DIR_DN, fi_ts}];
			end
		end
	end

	assign ev_dn = {`TCP_DIR_DN, s1_ts[6:1], `TCP_EVEN};
	assign od_dn = {`TCP_DIR_DN, s1_ts[6:1], `TCP_ODD};
	assign ev_up = {`TCP_DIR_UP, s1_ts[6:1], `TCP_EVEN};
	assign od_up = {`TCP_DIR_UP, s1_ts[6:1], `TCP_ODD};
	// handshake bits: the handler's with handshaking, else forced ones
	assign hs = hs_en ? {mf_mr, mf_mx} : `TCP_HS_FORCED;

	// downstream slot assembly
	always_comb begin
		logic [3:0] ec;
		logic [3:0] oc;
		logic [7:0] ed;
		ec = control_memory_code[ev_dn];
		oc = control_memory_code[od_dn];
		ed = control_memory_data[ev_dn];
		next_tx_byte = 8'h00;
		next_tx_oe   = 8'h00;
		if (!s1_ts[0]) begin
			// even slot carries the monitor byte from the handler
			if (ec == tcp_pkg::TCP_CODE_CI || ec == tcp_pkg::TCP_CODE_SIG) begin
				next_tx_byte = mf_dn_byte;
				next_tx_oe   = 8'hFF;
			end
		end else if (oc == tcp_pkg::TCP_CODE_SW64) begin
			// low pcm bits are ANDed, so the far end must send ones
			next_tx_byte = pcm_dn_byte & {6'h3F, hs};
			next_tx_oe   = 8'hFF;
		end else begin
			if (ec == tcp_pkg::TCP_CODE_CI || ec == tcp_pkg::TCP_CODE_SIG) begin
				next_tx_byte[`TCP_CI_MSB:`TCP_CI_LSB] =
					ed[`TCP_CI_MSB:`TCP_CI_LSB];
				next_tx_oe[`TCP_CI_MSB:`TCP_CI_LSB] = 4'hF;
				next_tx_byte[`TCP_HS_MSB:`TCP_HS_LSB] = hs;
				next_tx_oe[`TCP_HS_MSB:`TCP_HS_LSB]   = 2'h3;
			end
			if (is_16k(oc)) begin
				// central scheme: D pair taken from the chosen pcm pair
				next_tx_byte[`TCP_D_MSB:`TCP_D_LSB] =
					2'((pcm_dn_byte & pair_mask(oc)) >>
					(oc[1:0] * 2));
				next_tx_oe[`TCP_D_MSB:`TCP_D_LSB] = 2'h3;
			end else if (oc == tcp_pkg::TCP_CODE_HIZ &&
				ec == tcp_pkg::TCP_CODE_SIG) begin
				// signaling scheme drives all six bits from even data
				next_tx_byte[`TCP_SIG_MSB:`TCP_SIG_LSB] =
					ed[`TCP_SIG_MSB:`TCP_SIG_LSB];
				next_tx_oe[`TCP_SIG_MSB:`TCP_SIG_LSB] = 6'h3F;
			end
			// code 1011 under a 1000 even slot leaves D floating
		end
	end

	// upstream: switching towards pcm and change detection
	always_comb begin
		logic [3:0] ec;
		logic [3:0] oc;
		logic [7:0] ed;
		logic [7:0] od;
		ec = control_memory_code[ev_up];
		oc = control_memory_code[od_up];
		ed = control_memory_data[ev_up];
		od = control_memory_data[od_up];
		next_up_byte  = 8'h00;
		next_up_oe    = 8'h00;
		next_up_valid = 1'b0;
		ci_upd        = 1'b0;
		sig_upd       = 1'b0;
		ci_change     = 1'b0;
		sig_change    = 1'b0;
		if (s1_v && s1_ts[0]) begin
			if (is_16k(oc)) begin
				next_up_byte  = {6'h00, s1_rx[`TCP_D_MSB:`TCP_D_LSB]} <<
					(oc[1:0] * 2);
				next_up_oe    = pair_mask(oc);
				next_up_valid = 1'b1;
			end else if (oc == tcp_pkg::TCP_CODE_SW64) begin
				next_up_byte  = s1_rx;
				next_up_oe    = spread(data_memory_tri[od]);
				next_up_valid = 1'b1;
			end
			// code 0000 odd: D input is simply not used
			if (ec == tcp_pkg::TCP_CODE_CI) begin
				ci_upd    = 1'b1;
				ci_change = s1_rx[`TCP_CI_MSB:`TCP_CI_LSB] !=
					ed[`TCP_CI_MSB:`TCP_CI_LSB];
			end else if (ec == tcp_pkg::TCP_CODE_SIG &&
				oc == tcp_pkg::TCP_CODE_SIG) begin
				sig_upd = 1'b1;
				// two equal samples that differ from the stable value
				sig_change = sample_frame &&
					s1_rx[`TCP_SIG_MSB:`TCP_SIG_LSB] ==
					sig_last[s1_ts[6:1]] &&
					s1_rx[`TCP_SIG_MSB:`TCP_SIG_LSB] !=
					od[`TCP_SIG_MSB:`TCP_SIG_LSB];
			end
		end
	end

	// control and data memory: sweep, frame updates, software commands
	always_ff @(posedge clk) begin
		if (ce) begin
			if (sweep_busy) begin
				control_memory_code[sweep_idx] <=
					tcp_pkg::TCP_CODE_UNASSIGNED;
				data_memory_tri[sweep_idx] <= `TCP_TRI_RESET;
			end else begin
				// the whole byte is kept so the forced bits read back
				if (ci_upd || sig_upd)
					control_memory_data[ev_up] <= s1_rx;
				if (sig_change)
					control_memory_data[od_up][`TCP_SIG_MSB:`TCP_SIG_LSB]
						<= s1_rx[`TCP_SIG_MSB:`TCP_SIG_LSB];
				if (wr_cmd && op == `TCP_OP_CMWRITE) begin
					control_memory_code[memory_access_address_reg] <=
						pwdata[3:0];
					control_memory_data[memory_access_address_reg] <=
						memory_access_data_reg;
				end
				if (wr_cmd && op == `TCP_OP_TRISTATE)
					data_memory_tri[memory_access_address_reg] <=
						memory_access_data_reg[3:0];
			end
		end
	end

	// previous sample per channel pair for the last-look compare;
	// the sweep clears it so the first look never compares unknowns
	always_ff @(posedge clk) begin
		if (ce && sweep_busy)
			sig_last[sweep_idx[5:0]] <= 6'h00;
		else if (ce && sig_upd && sample_frame)
			sig_last[s1_ts[6:1]] <=
				s1_rx[`TCP_SIG_MSB:`TCP_SIG_LSB];
	end

	// stage 2 output registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fi_tx_valid  <= 1'b0;
			fi_tx_byte   <= 8'h00;
			fi_tx_oe     <= 8'h00;
			pcm_up_valid <= 1'b0;
			pcm_up_byte  <= 8'h00;
			pcm_up_oe    <= 8'h00;
			pcm_up_ptr   <= 8'h00;
		end else if (ce) begin
			fi_tx_valid  <= s1_v;
			fi_tx_byte   <= next_tx_byte;
			fi_tx_oe     <= s1_v ? next_tx_oe : 8'h00;
			pcm_up_valid <= next_up_valid;
			pcm_up_byte  <= next_up_byte;
			pcm_up_oe    <= next_up_oe;
			pcm_up_ptr   <= control_memory_data[od_up];
		end
	end

	// change address fifo; when full new changes are dropped
	assign full           = fifo_cnt == (FIFO_AW+1)'(FIFO_N);
	assign change_pending = fifo_cnt != '0;
	assign push = ce && !sweep_busy && (ci_change || sig_change);
	assign pop  = rd && paddr == `TCP_OFF_FIFO && change_pending;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			fifo_cnt <= '0;
		end else begin
			if (push && !full) begin
				fifo_mem[wr_ptr] <= s1_ts;
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if ((push && !full) && !pop)
				fifo_cnt <= fifo_cnt + 1'b1;
			else if (!(push && !full) && pop)
				fifo_cnt <= fifo_cnt - 1'b1;
		end
	end

	// overflow flag: a lost change in the clearing cycle still sets it
	always_ff @(posedge clk) begin
		if (!rst_n)
			ovf <= 1'b0;
		else if (push && full)
			ovf <= 1'b1;
		else if (wr && paddr == `TCP_OFF_STAT && pwdata[`TCP_STAT_OVF_BIT])
			ovf <= 1'b0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_dn_d_float;
		ce && s1_v && s1_ts[0] &&
		control_memory_code[od_dn] == tcp_pkg::TCP_CODE_HIZ &&
		control_memory_code[ev_dn] == tcp_pkg::TCP_CODE_CI
		|=> fi_tx_oe[`TCP_D_MSB:`TCP_D_LSB] == 2'h0 && fi_tx_valid;
	endproperty
	a_dn_d_float: assert property (p_dn_d_float)
		else $error("D bits driven under code 1011");

	property p_hs_forced;
		ce && s1_v && s1_ts[0] && !hs_en &&
		control_memory_code[ev_dn] == tcp_pkg::TCP_CODE_CI &&
		control_memory_code[od_dn] != tcp_pkg::TCP_CODE_SW64
		|=> fi_tx_byte[`TCP_HS_MSB:`TCP_HS_LSB] == 2'h3;
	endproperty
	a_hs_forced: assert property (p_hs_forced)
		else $error("handshake bits not forced high");

	property p_and_64k;
		ce && s1_v && s1_ts[0] &&
		control_memory_code[od_dn] == tcp_pkg::TCP_CODE_SW64
		|=> fi_tx_byte == ($past(pcm_dn_byte) & {6'h3F, $past(hs)});
	endproperty
	a_and_64k: assert property (p_and_64k)
		else $error("64k downstream low bits not ANDed");

	property p_up_16k_oe;
		ce && s1_v && s1_ts[0] && is_16k(control_memory_code[od_up])
		|=> pcm_up_valid && $countones(pcm_up_oe) == 2;
	endproperty
	a_up_16k_oe: assert property (p_up_16k_oe)
		else $error("16k upstream drives wrong number of bits");

	property p_cm_write;
		logic [7:0] a;
		logic [7:0] d;
		(wr_cmd && op == `TCP_OP_CMWRITE,
			a = memory_access_address_reg, d = memory_access_data_reg)
		|=> control_memory_code[a] == $past(pwdata[3:0]) &&
			control_memory_data[a] == d;
	endproperty
	a_cm_write: assert property (p_cm_write)
		else $error("memory command write not stored");

	property p_tristate;
		logic [7:0] a;
		(wr_cmd && op == `TCP_OP_TRISTATE, a = memory_access_address_reg)
		|=> data_memory_tri[a] == $past(memory_access_data_reg[3:0]);
	endproperty
	a_tristate: assert property (p_tristate)
		else $error("tristate command not stored");

	property p_ci_push;
		ce && ci_change && !full && !pop
		|=> fifo_cnt == $past(fifo_cnt) + 1'b1 && change_pending;
	endproperty
	a_ci_push: assert property (p_ci_push)
		else $error("indication change not queued");

	property p_sweep_end;
		ce && sweep_busy && sweep_idx == `TCP_IDX_LAST
		|=> !sweep_busy &&
			control_memory_code[`TCP_IDX_LAST] ==
			tcp_pkg::TCP_CODE_UNASSIGNED;
	endproperty
	a_sweep_end: assert property (p_sweep_end)
		else $error("memory reset sweep wrong");

	property p_sig_debounce;
		ce && sig_upd && !sample_frame |=> $stable(fifo_cnt) || $past(pop);
	endproperty
	a_sig_debounce: assert property (p_sig_debounce)
		else $error("signaling change outside a sample frame");

endmodule

// ===== test/tcp_line_model.sv
// line-side transceiver model: sends slot pairs, captures downstream bytes
`timescale 1ns/10ps

module tcp_line_model (
	input  wire logic       clk,
	output logic            fi_frame,
	output logic            fi_strobe,
	output logic      [6:0] fi_ts,
	output logic      [7:0] fi_rx_byte,
	input  wire logic [7:0] fi_tx_byte,
	input  wire logic [7:0] fi_tx_oe,
	input  wire logic       fi_tx_valid
);
	logic [7:0] tx_seen;
	logic [7:0] oe_seen;

	initial begin
		fi_frame = 1'b0;
		fi_strobe = 1'b0;
		fi_ts = 7'h00;
		fi_rx_byte = 8'h00;
		tx_seen = 8'h00;
		oe_seen = 8'h00;
	end

	// last downstream slot seen; the odd one of a pair lands last
	always @(posedge clk) begin
		if (fi_tx_valid === 1'b1) begin
			tx_seen <= fi_tx_byte;
			oe_seen <= fi_tx_oe;
		end
	end

	// one frame: monitor slot even, companion slot odd right after
	task automatic pair(input logic [6:0] ts, input logic [7:0] be,
		input logic [7:0] bo);
		@(posedge clk);
		fi_frame <= 1'b1;
		fi_strobe <= 1'b1;
		fi_ts <= ts;
		fi_rx_byte <= be;
		@(posedge clk);
		fi_frame <= 1'b0;
		fi_ts <= ts | 7'h01;
		fi_rx_byte <= bo;
		@(posedge clk);
		fi_strobe <= 1'b0;
		// released line shows no stale data
		fi_rx_byte <= ~bo;
	endtask
endmodule

// ===== test/tcp_top_test.sv
// self-checking bench of the timeslot channel preprocessor
`timescale 1ns/10ps
`include "tcp_consts.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
	error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end end

module tcp_top_test;
	logic        clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
	logic        last_err, fi_frame, fi_strobe, fi_tx_valid;
	logic        mf_mr, mf_mx, pcm_up_valid, change_pending;
	logic [6:0]  fi_ts;
	logic [7:0]  paddr, mf_dn_byte, pcm_dn_byte, fi_rx_byte, fi_tx_byte;
	logic [7:0]  fi_tx_oe, pcm_dn_ptr, pcm_up_ptr, pcm_up_byte, pcm_up_oe;
	logic [7:0]  up_ptr, up_byte, up_oe;
	logic [31:0] pwdata, prdata, rd;
	int          error_cnt, cmp_count, cyc;

	tcp_top tcp_top_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fi_frame(fi_frame), .fi_strobe(fi_strobe),
		.fi_ts(fi_ts), .fi_rx_byte(fi_rx_byte), .fi_tx_byte(fi_tx_byte),
		.fi_tx_oe(fi_tx_oe), .fi_tx_valid(fi_tx_valid),
		.mf_dn_byte(mf_dn_byte), .mf_mr(mf_mr), .mf_mx(mf_mx),
		.pcm_dn_ptr(pcm_dn_ptr), .pcm_dn_byte(pcm_dn_byte),
		.pcm_up_ptr(pcm_up_ptr), .pcm_up_byte(pcm_up_byte),
		.pcm_up_oe(pcm_up_oe), .pcm_up_valid(pcm_up_valid),
		.change_pending(change_pending));

	tcp_line_model tcp_line_model_inst (.clk(clk), .fi_frame(fi_frame),
		.fi_strobe(fi_strobe), .fi_ts(fi_ts), .fi_rx_byte(fi_rx_byte),
		.fi_tx_byte(fi_tx_byte), .fi_tx_oe(fi_tx_oe),
		.fi_tx_valid(fi_tx_valid));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// upstream pcm pulse is caught here, it stands one cycle only
	always @(posedge clk) begin
		if (pcm_up_valid === 1'b1) begin
			up_ptr <= pcm_up_ptr;
			up_byte <= pcm_up_byte;
			up_oe <= pcm_up_oe;
		end
	end

	// hang guard, far above the fewer than a thousand cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// apb master: setup, access until pready, then release
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cmd(input logic [7:0] a, input logic [7:0] op,
		input logic [7:0] d);
		apb(1'b1, `TCP_OFF_DATA, {24'h0, d});
		apb(1'b1, `TCP_OFF_ADDR, {24'h0, a});
		apb(1'b1, `TCP_OFF_CMD, {24'h0, op});
	endtask

	task automatic idle_wait();
		do apb(1'b0, `TCP_OFF_STAT, 32'h0); while (rd[8] !== 1'b0);
	endtask

	task automatic t_memory();
		idle_wait();
		cmd(8'h85, 8'h50, 8'h00);
		apb(1'b0, `TCP_OFF_CMD, 32'h0);
		`CHK("code after sweep", 8'h00, rd[7:0])
		cmd(8'h85, 8'h78, 8'h5A);
		cmd(8'h85, 8'h50, 8'h00);
		apb(1'b0, `TCP_OFF_CMD, 32'h0);
		`CHK("code loaded", 8'h08, rd[7:0])
		apb(1'b0, `TCP_OFF_DATA, 32'h0);
		`CHK("data loaded", 8'h5A, rd[7:0])
		cmd(8'h85, 8'h40, 8'h00);
		idle_wait();
		cmd(8'h85, 8'h50, 8'h00);
		apb(1'b0, `TCP_OFF_CMD, 32'h0);
		`CHK("code after reset cmd", 8'h00, rd[7:0])
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped err", 1'b1, last_err)
		$display("test memory done");
	endtask

	task automatic t_decentral();
		apb(1'b1, `TCP_OFF_CFG, 32'h0000_0100);
		cmd(8'h02, 8'h78, 8'hEB);
		cmd(8'h03, 8'h7B, 8'h00);
		tcp_line_model_inst.pair(7'h02, 8'h00, 8'hC0);
		repeat (4) @(posedge clk);
		`CHK("D floats", 2'b00, tcp_line_model_inst.oe_seen[7:6])
		`CHK("ind+hs", 6'h2B, tcp_line_model_inst.tx_seen[5:0])
		$display("test decentral done");
	endtask

	task automatic t_change();
		cmd(8'h82, 8'h78, 8'hFF);
		tcp_line_model_inst.pair(7'h02, 8'h00, 8'h3C);
		repeat (4) @(posedge clk);
		`CHK("no change", 1'b0, change_pending)
		tcp_line_model_inst.pair(7'h02, 8'h00, 8'h14);
		repeat (4) @(posedge clk);
		`CHK("change flag", 1'b1, change_pending)
		apb(1'b0, `TCP_OFF_FIFO, 32'h0);
		`CHK("fifo valid", 1'b1, rd[7])
		`CHK("fifo slot", 7'h03, rd[6:0])
		// the pop lands on the access edge, so look one edge later
		@(posedge clk);
		`CHK("popped", 1'b0, change_pending)
		$display("test change done");
	endtask

	task automatic t_central();
		logic [3:0] c;
		// D pair sits at bits 7-6, so subchannel select stays 00
		cmd(8'h0A, 8'h7A, 8'hC3);
		for (int i = 0; i < 4; i++) begin
			c = 4'h4 + 4'(i);
			cmd(8'h0B, {4'h7, c}, 8'h11);
			tcp_line_model_inst.pair(7'h0A, 8'h00, 8'h00);
			repeat (4) @(posedge clk);
			`CHK("dn ptr", 8'h11, pcm_dn_ptr)
			`CHK("dn D", 2'(8'h1B >> (2 * i)),
				tcp_line_model_inst.tx_seen[7:6])
			`CHK("dn D oe", 2'b11, tcp_line_model_inst.oe_seen[7:6])
		end
		cmd(8'h8B, 8'h75, 8'hA4);
		cmd(8'hA4, 8'h60, 8'h02);
		up_ptr = 8'h00;
		tcp_line_model_inst.pair(7'h0A, 8'h00, 8'h40);
		repeat (4) @(posedge clk);
		`CHK("up ptr", 8'hA4, up_ptr)
		`CHK("up D", 2'b01, up_byte[3:2])
		`CHK("up oe", 8'h0C, up_oe)
		$display("test central done");
	endtask

	task automatic t_signal();
		// signaling scheme downstream also carries a D idle code
		cmd(8'h02, 8'h7A, 8'h47);
		cmd(8'h82, 8'h7A, 8'hDF);
		cmd(8'h83, 8'h7A, 8'hDF);
		tcp_line_model_inst.pair(7'h02, 8'h00, 8'h47);
		repeat (4) @(posedge clk);
		`CHK("sig dn", 8'h47, tcp_line_model_inst.tx_seen)
		`CHK("sig dn oe", 8'hFF, tcp_line_model_inst.oe_seen)
		`CHK("first look", 1'b0, change_pending)
		tcp_line_model_inst.pair(7'h02, 8'h00, 8'h47);
		repeat (4) @(posedge clk);
		`CHK("sig change", 1'b1, change_pending)
		cmd(8'h83, 8'h50, 8'h00);
		apb(1'b0, `TCP_OFF_DATA, 32'h0);
		`CHK("stable", 6'h11, rd[7:2])
		apb(1'b0, `TCP_OFF_FIFO, 32'h0);
		`CHK("sig slot", 7'h03, rd[6:0])
		$display("test signal done");
	endtask

	task automatic t_switch64();
		// handshake on: handler bits 10 are ANDed into the pcm byte
		apb(1'b1, `TCP_OFF_CFG, 32'h0000_0101);
		mf_mr <= 1'b1;
		cmd(8'h0B, 8'h71, 8'h11);
		cmd(8'h8B, 8'h71, 8'hA4);
		tcp_line_model_inst.pair(7'h0A, 8'h00, 8'h5A);
		repeat (4) @(posedge clk);
		`CHK("dn 64k", 8'h1A, tcp_line_model_inst.tx_seen)
		`CHK("dn 64k oe", 8'hFF, tcp_line_model_inst.oe_seen)
		`CHK("up 64k", 8'h5A, up_byte)
		`CHK("up 64k oe", 8'h0C, up_oe)
		$display("test switch64 done");
	endtask

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mf_dn_byte = 8'h00;
		mf_mr = 1'b0;
		mf_mx = 1'b0;
		// distinct pairs; low pair at 11 as the far end must send
		pcm_dn_byte = 8'h1B;
		error_cnt = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_memory();
		t_decentral();
		t_change();
		t_signal();
		t_central();
		t_switch64();
		conclude();
	end
endmodule
